/* File: inc/sif_pkg.sv */
// Purpose: Shared constants and carriers for the spindle interface block
// Assumes: 32-bit register port, one word per register, byte addresses
// Notes:   Status and control layouts are packed structs, LSB last

package sif_pkg;

	// Register port widths
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00; // Rotation and strobes
	localparam logic [7:0] OFF_SPDCMD = 8'h04; // Speed command word
	localparam logic [7:0] OFF_SCODE  = 8'h08; // Speed code word
	localparam logic [7:0] OFF_STATUS = 8'h0C; // Status flags
	localparam logic [7:0] OFF_ACT    = 8'h10; // Actual speed word
	localparam logic [7:0] OFF_LOAD   = 8'h14; // Load meter value
	localparam logic [7:0] OFF_MSPD   = 8'h18; // Motor speed value
	localparam logic [7:0] OFF_ALARM  = 8'h1C; // Alarm number byte
	localparam logic [7:0] OFF_LIMIT  = 8'h20; // Permitted speed range

	// Scaling limits
	localparam logic [15:0] LOAD_MAX = 16'h7FE1; // 32737, +10 V
	localparam logic [15:0] MSPD_MAX = 16'h4000; // +16384, top speed
	localparam logic [15:0] MSPD_MIN = 16'hC000; // -16384

	// Stop detection and ramp step while braking
	localparam logic [15:0] ZERO_LEVEL = 16'h0010;
	localparam logic [15:0] RAMP_STEP  = 16'h0040;

	// Interlock states, Gray along off, run, brake; brake back to off flips both bits
	typedef enum logic [1:0] {
		ST_OFF   = 2'b00,
		ST_RUN   = 2'b01,
		ST_DECEL = 2'b11
	} sif_state_e;

	// Control register layout
	typedef struct packed {
		logic [27:0] resv;
		logic        speed_code_strobe;
		logic        misc_code_strobe;
		logic        rev;
		logic        fwd;
	} sif_ctrl_s;

	// Permitted speed range register layout
	typedef struct packed {
		logic [15:0] hi;
		logic [15:0] lo;
	} sif_limit_s;

	// Flags reported by the amplifier and control internals
	typedef struct packed {
		logic coder_orient_near;
		logic sensor_orient_done;
		logic sensor_orient_near;
		logic slave_active;
		logic one_rev_seen;
		logic incremental_orient_active;
		logic unclamp_done;
		logic clamp_done;
		logic surface_speed_active;
		logic contour_axis_active;
		logic sync_active;
		logic phase_sync_active;
		logic sync_alarm;
		logic rigid_tap_active;
		logic spindle_alarm;
	} sif_amp_s;

	// Status register layout
	typedef struct packed {
		logic [10:0] resv;
		logic        ready;
		logic        contactor_off;
		logic        speed_nonzero_flag;
		logic        speed_fluctuation_alarm;
		logic        misc_code_strobe;
		logic        speed_code_strobe;
		sif_amp_s    amp;
	} sif_status_s;

	// Reset values
	localparam sif_ctrl_s  CTRL_RST   = '0;
	localparam logic [15:0] SPD_RST   = 16'h0000;
	localparam logic [31:0] SCODE_RST = 32'h0000_0000;
	localparam sif_limit_s LIMIT_RST  = '{hi: 16'hFFFF, lo: 16'h0000};

endpackage : sif_pkg

/* File: core/sif_core.sv */
// Purpose: Spindle interface: stop interlock, status flags, data words
// Assumes: Single 100 MHz clock, synchronous active-low reset
// Notes:   Stop pin is synchronised; all else comes from same-clock logic
//
// The implementer's own choices: the register addresses and the strobed register port.

`timescale 1ns/1ps

module sif_core (
	input  wire logic                 clk_in,
	input  wire logic                 reset_n_in,
	input  wire logic                 ce_in,
	input  wire logic                 emergency_stop_n_in,
	input  wire logic [7:0]           addr_in,
	input  wire logic [31:0]          wdata_in,
	input  wire logic                 wr_in,
	input  wire logic                 rd_in,
	input  wire sif_pkg::sif_amp_s    amp_in,
	input  wire logic [7:0]           alarm_code_in,
	input  wire logic [15:0]          meas_rpm_in,
	input  wire logic [15:0]          meas_speed_in,
	input  wire logic [15:0]          load_raw_in,
	output logic [31:0]               rdata_out,
	output logic                      contactor_off_out,
	output logic                      motor_enable_out,
	output logic [15:0]               motor_cmd_out,
	output sif_pkg::sif_status_s      status_out
);

	// Stop pin synchroniser stages
	logic        est_s1_q;
	logic        est_s2_q;
	logic        est_s3_q;
	logic        est_n_q;     // Filtered stop level, 1 = run allowed

	// Software registers
	sif_pkg::sif_ctrl_s  ctrl_q;
	sif_pkg::sif_limit_s limit_q;
	logic [15:0]         speed_command_word_q;
	logic [31:0]         speed_code_word_q;

	// Interlock state
	sif_pkg::sif_state_e state_q;
	sif_pkg::sif_state_e state_d;

	// Reported data words
	logic [15:0] actual_speed_word_q;
	logic [15:0] load_meter_value_q;
	logic [15:0] motor_speed_value_q;
	logic [7:0]  alarm_number_byte_q;

	// Output flops
	logic                contactor_off_q;
	logic                motor_enable_q;
	logic [15:0]         motor_cmd_q;
	sif_pkg::sif_status_s status_q;
	logic [31:0]         rdata_q;

	// Derived combinational terms
	logic        moving;      // Motor speed above zero level
	logic        dir_ok;      // Exactly one rotation command
	logic        out_range;   // Measured speed outside permitted range

	// Magnitude of a signed 16-bit speed; most negative gives 32768 unsigned
	function automatic logic [15:0] mag16(input logic [15:0] v);
		logic [15:0] r;
		r = v[15] ? 16'(-v) : v;
		return r;
	endfunction : mag16

	// Three-flop sampler for the asynchronous stop pin
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			est_s1_q <= 1'b0;
			est_s2_q <= 1'b0;
			est_s3_q <= 1'b0;
		end else if (ce_in) begin
			est_s1_q <= emergency_stop_n_in;
			est_s2_q <= est_s1_q;
			est_s3_q <= est_s2_q;
		end
	end

	// Level only moves once the two later stages agree
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			est_n_q <= 1'b0;
		end else if (ce_in && (est_s2_q == est_s3_q)) begin
			est_n_q <= est_s3_q;
		end
	end

	// Register writes; no wait states on this port
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			ctrl_q               <= sif_pkg::CTRL_RST;
			speed_command_word_q <= sif_pkg::SPD_RST;
			speed_code_word_q    <= sif_pkg::SCODE_RST;
			limit_q              <= sif_pkg::LIMIT_RST;
		end else if (ce_in && wr_in) begin
			case (addr_in)
				sif_pkg::OFF_CTRL: begin
					// Reserved bits are never stored
					ctrl_q      <= sif_pkg::sif_ctrl_s'(wdata_in);
					ctrl_q.resv <= '0;
				end
				sif_pkg::OFF_SPDCMD: begin
					speed_command_word_q <= wdata_in[15:0];
				end
				sif_pkg::OFF_SCODE: begin
					speed_code_word_q <= wdata_in;
				end
				sif_pkg::OFF_LIMIT: begin
					limit_q <= sif_pkg::sif_limit_s'(wdata_in);
				end
				// Read-only or unmapped: write ignored
				default: begin
				end
			endcase
		end
	end

	// Derived terms for the interlock and alarms
	always_comb begin
		moving    = mag16(meas_speed_in) > sif_pkg::ZERO_LEVEL;
		dir_ok    = ctrl_q.fwd ^ ctrl_q.rev;
		out_range = (meas_rpm_in < limit_q.lo) ||
			(meas_rpm_in > limit_q.hi);
	end

	// Interlock next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			sif_pkg::ST_OFF: begin
				if (est_n_q) begin
					state_d = sif_pkg::ST_RUN;
				end
			end
			sif_pkg::ST_RUN: begin
				if (!est_n_q) begin
					state_d = moving ? sif_pkg::ST_DECEL
						: sif_pkg::ST_OFF;
				end
			end
			// Braking ends only at standstill
			sif_pkg::ST_DECEL: begin
				if (!moving) begin
					state_d = sif_pkg::ST_OFF;
				end
			end
			default: begin
				state_d = sif_pkg::ST_OFF;
			end
		endcase
	end

	// Interlock state register
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			state_q <= sif_pkg::ST_OFF;
		end else if (ce_in) begin
			state_q <= state_d;
		end
	end

	// Contactor off while stopped under stop; kept on during braking
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			contactor_off_q <= 1'b1;
		end else if (ce_in) begin
			contactor_off_q <= (state_q == sif_pkg::ST_OFF) && !est_n_q;
		end
	end

	// Drive enable; both commands at once means stop
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			motor_enable_q <= 1'b0;
		end else if (ce_in) begin
			motor_enable_q <= est_n_q && dir_ok &&
				(state_q == sif_pkg::ST_RUN) &&
				!amp_in.spindle_alarm;
		end
	end

	// Speed reference to the drive, ramped to zero when braking
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			motor_cmd_q <= 16'h0000;
		end else if (ce_in) begin
			case (state_q)
				sif_pkg::ST_RUN: begin
					// hold reference so braking ramps from it
					if (!est_n_q) begin
						motor_cmd_q <= motor_cmd_q;
					end else if (!dir_ok) begin
						motor_cmd_q <= 16'h0000;
					end else if (ctrl_q.fwd) begin
						motor_cmd_q <= speed_command_word_q;
					end else begin
						motor_cmd_q <= 16'(-speed_command_word_q);
					end
				end
				sif_pkg::ST_DECEL: begin
					if (mag16(motor_cmd_q) <= sif_pkg::RAMP_STEP) begin
						motor_cmd_q <= 16'h0000;
					end else if (motor_cmd_q[15]) begin
						motor_cmd_q <= motor_cmd_q + sif_pkg::RAMP_STEP;
					end else begin
						motor_cmd_q <= motor_cmd_q - sif_pkg::RAMP_STEP;
					end
				end
				// Off: nothing commanded
				default: begin
					motor_cmd_q <= 16'h0000;
				end
			endcase
		end
	end

	// Data words sampled from the amplifier side
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			actual_speed_word_q <= 16'h0000;
			load_meter_value_q  <= 16'h0000;
			motor_speed_value_q <= 16'h0000;
			alarm_number_byte_q <= 8'h00;
		end else if (ce_in) begin
			actual_speed_word_q <= meas_rpm_in;
			load_meter_value_q <= (load_raw_in > sif_pkg::LOAD_MAX) ?
				sif_pkg::LOAD_MAX : load_raw_in;
			if ($signed(meas_speed_in) > $signed(sif_pkg::MSPD_MAX)) begin
				motor_speed_value_q <= sif_pkg::MSPD_MAX;
			end else if ($signed(meas_speed_in) <
				$signed(sif_pkg::MSPD_MIN)) begin
				motor_speed_value_q <= sif_pkg::MSPD_MIN;
			end else begin
				motor_speed_value_q <= meas_speed_in;
			end
			alarm_number_byte_q <= amp_in.spindle_alarm ?
				alarm_code_in : 8'h00;
		end
	end

	// Status flags; amplifier flags pass through one register
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			status_q               <= '0;
			status_q.contactor_off <= 1'b1;
		end else if (ce_in) begin
			status_q.resv  <= '0;
			status_q.ready <= (state_q == sif_pkg::ST_RUN);
			status_q.contactor_off <=
				(state_q == sif_pkg::ST_OFF) && !est_n_q;
			status_q.speed_nonzero_flag <= |speed_command_word_q;
			status_q.speed_fluctuation_alarm <= out_range;
			status_q.misc_code_strobe  <= ctrl_q.misc_code_strobe;
			status_q.speed_code_strobe <= ctrl_q.speed_code_strobe;
			status_q.amp <= amp_in;
		end
	end

	// Read data stand one cycle, zero otherwise
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			rdata_q <= 32'h0000_0000;
		end else if (ce_in) begin
			rdata_q <= 32'h0000_0000;
			if (rd_in) begin
				case (addr_in)
					sif_pkg::OFF_CTRL:   rdata_q <= ctrl_q;
					sif_pkg::OFF_SPDCMD: rdata_q <= {16'h0000,
						speed_command_word_q};
					sif_pkg::OFF_SCODE:  rdata_q <= speed_code_word_q;
					sif_pkg::OFF_STATUS: rdata_q <= status_q;
					sif_pkg::OFF_ACT:    rdata_q <= {16'h0000,
						actual_speed_word_q};
					sif_pkg::OFF_LOAD:   rdata_q <= {16'h0000,
						load_meter_value_q};
					sif_pkg::OFF_MSPD:   rdata_q <= {16'h0000,
						motor_speed_value_q};
					sif_pkg::OFF_ALARM:  rdata_q <= {24'h00_0000,
						alarm_number_byte_q};
					sif_pkg::OFF_LIMIT:  rdata_q <= limit_q;
					// Unmapped reads as zero
					default:             rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Ports straight from flops
	assign rdata_out         = rdata_q;
	assign contactor_off_out = contactor_off_q;
	assign motor_enable_out  = motor_enable_q;
	assign motor_cmd_out     = motor_cmd_q;
	assign status_out        = status_q;

	// Checks on the interlock and reported words
	property p_stop_blocks_run;
		@(posedge clk_in) disable iff (!reset_n_in)
		(ce_in && !est_n_q) |=> !motor_enable_q;
	endproperty
	a_stop_blocks_run: assert property (p_stop_blocks_run)
		else $error("Motor enabled under stop");

	property p_contactor_at_rest;
		@(posedge clk_in) disable iff (!reset_n_in)
		(ce_in && state_q == sif_pkg::ST_OFF && !est_n_q)
			|=> contactor_off_q;
	endproperty
	a_contactor_at_rest: assert property (p_contactor_at_rest)
		else $error("Contactor not off at rest under stop");

	property p_brake_before_off;
		@(posedge clk_in) disable iff (!reset_n_in)
		(ce_in && state_q == sif_pkg::ST_RUN && !est_n_q && moving)
			|=> (state_q == sif_pkg::ST_DECEL) && !contactor_off_q
			&& !motor_enable_q;
	endproperty
	a_brake_before_off: assert property (p_brake_before_off)
		else $error("Stop while turning skipped braking");

	property p_decel_contactor_on;
		@(posedge clk_in) disable iff (!reset_n_in)
		(state_q == sif_pkg::ST_DECEL) |-> !contactor_off_q;
	endproperty
	a_decel_contactor_on: assert property (p_decel_contactor_on)
		else $error("Contactor dropped while braking");

	property p_release_ready;
		@(posedge clk_in) disable iff (!reset_n_in)
		(ce_in && state_q == sif_pkg::ST_OFF && est_n_q)
			##1 (ce_in && dir_ok && est_n_q && !amp_in.spindle_alarm)
			|=> motor_enable_q;
	endproperty
	a_release_ready: assert property (p_release_ready)
		else $error("No start after stop released");

	property p_nonzero_flag;
		@(posedge clk_in) disable iff (!reset_n_in)
		ce_in |=> (status_q.speed_nonzero_flag ==
			($past(speed_command_word_q) != 16'h0000));
	endproperty
	a_nonzero_flag: assert property (p_nonzero_flag)
		else $error("Nonzero flag disagrees with command");

	property p_fluct_alarm;
		@(posedge clk_in) disable iff (!reset_n_in)
		(ce_in && out_range) |=> status_q.speed_fluctuation_alarm;
	endproperty
	a_fluct_alarm: assert property (p_fluct_alarm)
		else $error("Out of range speed not flagged");

	property p_load_cap;
		@(posedge clk_in) disable iff (!reset_n_in)
		load_meter_value_q <= sif_pkg::LOAD_MAX;
	endproperty
	a_load_cap: assert property (p_load_cap)
		else $error("Load word above full scale");

	property p_mspd_range;
		@(posedge clk_in) disable iff (!reset_n_in)
		mag16(motor_speed_value_q) <= sif_pkg::MSPD_MAX;
	endproperty
	a_mspd_range: assert property (p_mspd_range)
		else $error("Motor speed word beyond full scale");

	property p_alarm_byte_zero;
		@(posedge clk_in) disable iff (!reset_n_in)
		!status_q.amp.spindle_alarm |-> (alarm_number_byte_q == 8'h00);
	endproperty
	a_alarm_byte_zero: assert property (p_alarm_byte_zero)
		else $error("Alarm byte nonzero without alarm");

	// Main scenarios
	c_brake: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		state_q == sif_pkg::ST_DECEL ##1 state_q == sif_pkg::ST_OFF);
	c_restart: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		contactor_off_q ##[1:20] motor_enable_q);
	c_alarm: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		alarm_number_byte_q != 8'h00);

endmodule : sif_core

/* File: bench/sif_plant.sv */
// Purpose: Motor and drive plant that answers the spindle interface
// Assumes: Shaft speed tracks the signed reference one cycle late
// Notes:   No inertia, so braking time is set by the reference ramp alone

`timescale 1ns/1ps

module sif_plant (
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	input  wire logic [15:0] motor_cmd_in,
	output logic      [15:0] meas_speed_out
);
	// measured speed follows the ramped reference
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			meas_speed_out <= 16'h0000;
		end else begin
			meas_speed_out <= motor_cmd_in;
		end
	end
endmodule : sif_plant

/* File: bench/spindle_interface_status_tb.sv */
// Purpose: Self-checking bench for the spindle interface core
// Assumes: Clock enable high except for one write test; plant closes the speed loop
// Notes:   Expected values come from small integer models below

`timescale 1ns/1ps

module spindle_interface_status_tb;
	logic                 clk_in;
	logic                 reset_n_in;
	logic                 ce;
	logic                 stop_n;
	logic [7:0]           addr;
	logic [31:0]          wdata;
	logic                 wr;
	logic                 rd;
	sif_pkg::sif_amp_s    amp;
	logic [7:0]           acode;
	logic [15:0]          rpm;
	logic [15:0]          load;
	logic [15:0]          meas;
	logic [31:0]          rdata;
	logic                 coff;
	logic                 men;
	logic [15:0]          mcmd;
	sif_pkg::sif_status_s status;
	int                   error_cnt;
	int                   n_checks;
	int                   cyc;
	logic [31:0]          rv;
	logic [31:0]          ctl;
	logic [15:0]          spd;
	logic [31:0]          lim;

	sif_core dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce),
		.emergency_stop_n_in(stop_n), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .amp_in(amp), .alarm_code_in(acode),
		.meas_rpm_in(rpm), .meas_speed_in(meas), .load_raw_in(load),
		.rdata_out(rdata), .contactor_off_out(coff),
		.motor_enable_out(men), .motor_cmd_out(mcmd), .status_out(status));

	sif_plant plant (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.motor_cmd_in(mcmd), .meas_speed_out(meas));

	// Free-running 100 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	task automatic report_and_stop();
		if (error_cnt == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	// Hang guard, well above the under 2000 cycles the run needs
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask : bus_wr

	// Read data stand only in the cycle after the strobe
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_in);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk_in);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : bus_rd

	// Signed motor speed clamped to the full-scale magnitude
	function automatic logic [31:0] m_mspd(input logic [15:0] v);
		int s;
		s = $signed(v);
		if (s > 16384) return 32'h0000_4000;
		if (s < -16384) return 32'h0000_C000;
		return {16'h0000, v};
	endfunction : m_mspd

	// Status word as software sees it while the stop is released
	function automatic logic [31:0] m_status(input sif_pkg::sif_amp_s a,
		input logic [31:0] c, input logic [15:0] s, input logic [15:0] r,
		input logic [31:0] l);
		logic fl;
		fl = (r < l[15:0]) || (r > l[31:16]);
		return {11'h000, 1'b1, 1'b0, (s != 16'h0000), fl, c[2], c[3], a};
	endfunction : m_status

	// Stop, clear, reload commands, release, then brake from speed if enabled
	task automatic spin(input logic [31:0] c, input logic [15:0] s,
		input logic en, input logic [15:0] ecmd);
		int n;
		stop_n <= 1'b0;
		// controller clears commands together with the stop
		bus_wr(sif_pkg::OFF_CTRL, 32'h0000_0000);
		bus_wr(sif_pkg::OFF_SPDCMD, 32'h0000_0000);
		repeat (8) @(posedge clk_in);
		#1;
		check(coff, 1'b1);
		bus_wr(sif_pkg::OFF_SPDCMD, {16'h0000, s});
		bus_wr(sif_pkg::OFF_CTRL, c);
		repeat (3) @(posedge clk_in);
		#1;
		check(men, 1'b0);
		stop_n <= 1'b1;
		n = 0;
		while (men !== 1'b1 && n < 20) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		check(men, en);
		check(mcmd, ecmd);
		if (en) begin
			// Plant and speed word each add a cycle of lag
			repeat (2) @(posedge clk_in);
			bus_rd(sif_pkg::OFF_MSPD, rv);
			check(rv, m_mspd(ecmd));
			stop_n <= 1'b0;
			n = 0;
			while (coff !== 1'b1 && n < 2000) begin
				@(posedge clk_in);
				#1;
				n++;
				if (n > 5) check(men, 1'b0);
			end
			check(coff, 1'b1);
			check(($signed(meas) <= 16 && $signed(meas) >= -16), 1'b1);
			check((n > 8), 1'b1);
		end
	endtask : spin

	initial begin
		reset_n_in = 1'b0;
		ce         = 1'b1;
		stop_n     = 1'b1;
		addr       = 8'h00;
		wdata      = 32'h0000_0000;
		wr         = 1'b0;
		rd         = 1'b0;
		amp        = '0;
		acode      = 8'h00;
		rpm        = 16'h0000;
		load       = 16'h0000;
		error_cnt  = 0;
		n_checks   = 0;
		cyc        = 0;
		void'($urandom(54501));
		repeat (4) @(posedge clk_in);
		#1;
		check(coff, 1'b1);
		check(status, 32'h0008_0000);
		reset_n_in <= 1'b1;
		// Register map basics: reset limit, unmapped and reserved bits
		bus_rd(sif_pkg::OFF_LIMIT, rv);
		check(rv, 32'hFFFF_0000);
		bus_rd(8'h40, rv);
		check(rv, 32'h0000_0000);
		bus_wr(sif_pkg::OFF_CTRL, 32'hFFFF_FFFC);
		bus_rd(sif_pkg::OFF_CTRL, rv);
		check(rv, 32'h0000_000C);
		// Clock enable low: a write must not be taken
		ce <= 1'b0;
		bus_wr(sif_pkg::OFF_SCODE, 32'h1234_5678);
		ce <= 1'b1;
		bus_rd(sif_pkg::OFF_SCODE, rv);
		check(rv, 32'h0000_0000);
		// Random flag and data word sweeps
		for (int i = 0; i < 8; i++) begin
			amp   <= sif_pkg::sif_amp_s'(15'($urandom()));
			acode <= 8'($urandom());
			rpm   <= 16'($urandom());
			load  <= (i == 1) ? 16'hFFFF : 16'($urandom());
			spd   = (i == 0) ? 16'h0000 : 16'($urandom());
			ctl   = {28'h0000_000, 2'($urandom()), 2'b00};
			lim   = $urandom();
			bus_wr(sif_pkg::OFF_SPDCMD, {16'h0000, spd});
			bus_wr(sif_pkg::OFF_CTRL, ctl);
			bus_wr(sif_pkg::OFF_LIMIT, lim);
			bus_wr(sif_pkg::OFF_SCODE, lim ^ 32'h5A5A_A5A5);
			bus_wr(sif_pkg::OFF_STATUS, 32'hFFFF_FFFF);
			bus_rd(sif_pkg::OFF_STATUS, rv);
			check(rv, m_status(amp, ctl, spd, rpm, lim));
			check(status, m_status(amp, ctl, spd, rpm, lim));
			bus_rd(sif_pkg::OFF_SCODE, rv);
			check(rv, lim ^ 32'h5A5A_A5A5);
			bus_rd(sif_pkg::OFF_SPDCMD, rv);
			check(rv, {16'h0000, spd});
			bus_rd(sif_pkg::OFF_ACT, rv);
			check(rv, {16'h0000, rpm});
			bus_rd(sif_pkg::OFF_LOAD, rv);
			check(rv, (load > 16'd32737) ? 32'd32737 : {16'h0000, load});
			bus_rd(sif_pkg::OFF_ALARM, rv);
			check(rv, amp.spindle_alarm ? {24'h0, acode} : 32'h0);
		end
		amp   <= '0;
		rpm   <= 16'h0000;
		// Interlock in both directions at full command, reverse at a low command, then a refusal
		spin(32'h0000_0001, 16'h7FFF, 1'b1, 16'h7FFF);
		spin(32'h0000_0002, 16'h7FFF, 1'b1, 16'h8001);
		spin(32'h0000_0002, 16'h0100, 1'b1, 16'hFF00);
		spin(32'h0000_0003, 16'h0100, 1'b0, 16'h0000);
		report_and_stop();
	end
endmodule : spindle_interface_status_tb
